// File: tb/cct_pin_model.sv
`timescale 1ns/1ps
module cct_pin_model (
  // clock
  input wire logic sys_clk,
  // block side of the pins
  input wire logic [3:0] channel_pin_out,
  input wire logic [3:0] channel_pin_oe,
  output logic [3:0] channel_pin_in
);
  logic [3:0] ext_q = 4'h0;
  // a driven pin reads back the block's own level
  assign channel_pin_in = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & ext_q);
  task automatic drive(input logic [3:0] lvl);
    @(posedge sys_clk);
    ext_q <= lvl;
  endtask
endmodule

// File: tb/cct_timer_chk.sv
`timescale 1ns/1ps
module cct_timer_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register bus
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // interrupt and pins
  input wire logic irq,
  input wire logic [3:0] channel_pin_out,
  input wire logic [3:0] channel_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // irq needs a nonzero enable, and only a bus write can give one
  logic ien_set_q;
  logic ien_set_d;
  wire ack = (avs_read || avs_write) && !avs_waitrequest;
  assign ien_set_d = ien_set_q || (ack && avs_write && avs_address[10:2] == 9'h122 && avs_writedata[7:0] != 8'h00);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ien_set_q <= 1'b0;
    end else begin
      ien_set_q <= ien_set_d;
    end
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> s_ack) else $error("no answer after one wait cycle");
  AST_ACK_ONCE: assert property (s_ack |=> !ack) else $error("answer repeated");
  AST_IDLE_READY: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("wait while idle");
  AST_RD_UPPER: assert property (s_ack ##0 avs_read |-> avs_readdata[31:16] == 16'h0000) else $error("upper bits set");
  AST_UNMAPPED: assert property (s_ack ##0 (avs_read && !avs_address[10]) |-> avs_readdata == 32'h0) else $error("unmapped read");
  AST_RST_PINS: assert property ($fell(rst) |-> channel_pin_oe == 4'hF && channel_pin_out == 4'h0) else $error("pins after reset");
  AST_RST_IRQ: assert property ($fell(rst) |-> !irq) else $error("irq after reset");
  AST_IRQ_QUIET: assert property (!ien_set_q |-> !irq) else $error("irq without enable");
endmodule

bind cct_timer cct_timer_chk u_cct_timer_chk (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .channel_pin_out(channel_pin_out),
  .channel_pin_oe(channel_pin_oe));

// File: tb/test_cct_timer.sv
`timescale 1ns/1ps
module test_cct_timer;
  logic sys_clk;
  logic rst;
  logic [10:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic fast_osc_tick;
  logic capture_alt_tick;
  logic ext_clk_pin;
  logic [3:0] channel_pin_in;
  logic [3:0] channel_pin_out;
  logic [3:0] channel_pin_oe;
  int bad_count;
  int checked;
  logic [31:0] rd_val;

  cct_timer u_cct_timer (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .fast_osc_tick(fast_osc_tick),
    .capture_alt_tick(capture_alt_tick), .ext_clk_pin(ext_clk_pin), .channel_pin_in(channel_pin_in),
    .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe));
  cct_pin_model u_cct_pin_model (.sys_clk(sys_clk), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe), .channel_pin_in(channel_pin_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one request held until waitrequest is sampled low, then an idle edge
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd_val = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      wrap_up();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [10:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd_val, exp);
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic poll(input logic [10:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rd_val & m) !== m && n < 300);
    check(rd_val & m, m);
    if ((rd_val & m) !== m) begin
      wrap_up();
    end
  endtask

  initial begin
    rst = 1'b1;
    avs_address = 11'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    fast_osc_tick = 1'b0;
    capture_alt_tick = 1'b0;
    ext_clk_pin = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(11'h480, 32'h0);
    rd(11'h4A0, 32'hFFFF);
    rd(11'h498, 32'h0);
    wr(11'h000, 32'hFF);
    rd(11'h000, 32'h0);
    // compare on A and C, only A may interrupt
    wr(11'h4A0, 32'h10);
    wr(11'h4B0, 32'h20);
    wr(11'h488, 32'h01);
    wr(11'h480, 32'h80);
    poll(11'h48C, 32'h05);
    wr(11'h480, 32'h00);
    check({31'h0, irq}, 32'h1);
    rd(11'h48C, 32'h05);
    wr(11'h48C, 32'hFF);
    rd(11'h48C, 32'h05);
    wr(11'h48C, 32'h04);
    rd(11'h48C, 32'h04);
    check({31'h0, irq}, 32'h0);
    wr(11'h48C, 32'hFF);
    wr(11'h48C, 32'h00);
    rd(11'h48C, 32'h04);
    wr(11'h48C, 32'h00);
    rd(11'h48C, 32'h00);
    // overflow
    wr(11'h498, 32'hFFF0);
    wr(11'h488, 32'h80);
    wr(11'h480, 32'h80);
    poll(11'h48C, 32'h80);
    check({31'h0, irq}, 32'h1);
    wr(11'h480, 32'h00);
    bus(1'b0, 11'h48C, 32'h0);
    wr(11'h48C, 32'h00);
    rd(11'h48C, 32'h00);
    check({31'h0, irq}, 32'h0);
    // capture A on rise, B on fall; clear on match A must not act
    wr(11'h490, 32'h54);
    wr(11'h4A0, 32'h05);
    wr(11'h484, 32'h80);
    wr(11'h498, 32'h00);
    wr(11'h480, 32'h80);
    poll(11'h498, 32'h40);
    u_cct_pin_model.drive(4'h3);
    poll(11'h48C, 32'h01);
    check(rd_val & 32'h03, 32'h01);
    u_cct_pin_model.drive(4'h1);
    poll(11'h48C, 32'h02);
    bus(1'b0, 11'h4A0, 32'h0);
    check({31'h0, rd_val > 32'h40}, 32'h1);
    // fast oscillator source counts only on its tick
    wr(11'h480, 32'h00);
    wr(11'h484, 32'h60);
    wr(11'h498, 32'h00);
    wr(11'h480, 32'h80);
    rd(11'h498, 32'h0);
    fast_osc_tick <= 1'b1;
    repeat (5) @(posedge sys_clk);
    fast_osc_tick <= 1'b0;
    wr(11'h480, 32'h00);
    rd(11'h498, 32'h05);
    // alternate capture trigger needs the channel A option bit
    wr(11'h484, 32'h00);
    wr(11'h490, 32'h04);
    bus(1'b0, 11'h48C, 32'h0);
    wr(11'h48C, 32'h00);
    wr(11'h480, 32'h80);
    capture_alt_tick <= 1'b1;
    @(posedge sys_clk);
    capture_alt_tick <= 1'b0;
    bus(1'b0, 11'h48C, 32'h0);
    check(rd_val & 32'h01, 32'h00);
    wr(11'h490, 32'h0C);
    capture_alt_tick <= 1'b1;
    @(posedge sys_clk);
    capture_alt_tick <= 1'b0;
    poll(11'h48C, 32'h01);
    // initial levels reach compare pins only; pwm ignores io control
    wr(11'h480, 32'h00);
    wr(11'h484, 32'h0F);
    wr(11'h4C8, 32'h04);
    @(posedge sys_clk);
    check({28'h0, channel_pin_out}, 32'hE);
    check({28'h0, channel_pin_oe}, 32'hA);
    wr(11'h480, 32'h01);
    @(posedge sys_clk);
    check({28'h0, channel_pin_out}, 32'hF);
    // buffered capture on A moves the old A value into C
    wr(11'h480, 32'h10);
    wr(11'h4C8, 32'h00);
    wr(11'h490, 32'h06);
    wr(11'h494, 32'h04);
    wr(11'h4A0, 32'h1234);
    bus(1'b0, 11'h48C, 32'h0);
    wr(11'h48C, 32'h00);
    u_cct_pin_model.drive(4'h0);
    poll(11'h48C, 32'h01);
    rd(11'h4B0, 32'h1234);
    // triggered pwm waits for a rise on pin A, then runs one count past match A and stops
    wr(11'h480, 32'h00);
    wr(11'h484, 32'h00);
    wr(11'h4C0, 32'h01);
    wr(11'h4C4, 32'h01);
    wr(11'h4A0, 32'h0100);
    wr(11'h498, 32'h0000);
    wr(11'h480, 32'h82);
    rd(11'h498, 32'h0);
    u_cct_pin_model.drive(4'h1);
    poll(11'h498, 32'h100);
    rd(11'h498, 32'h101);
    wrap_up();
  end
endmodule

// File: verilog/cct_pkg.sv
package cct_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [8:0] IDX_MODE = 9'h120;
  localparam logic [8:0] IDX_CTL1 = 9'h121;
  localparam logic [8:0] IDX_IEN = 9'h122;
  localparam logic [8:0] IDX_STAT = 9'h123;
  localparam logic [8:0] IDX_IOAB = 9'h124;
  localparam logic [8:0] IDX_IOCD = 9'h125;
  localparam logic [8:0] IDX_CNT = 9'h126;
  localparam logic [8:0] IDX_GRA = 9'h128;
  localparam logic [8:0] IDX_GRB = 9'h12A;
  localparam logic [8:0] IDX_GRC = 9'h12C;
  localparam logic [8:0] IDX_GRD = 9'h12E;
  localparam logic [8:0] IDX_CTL2 = 9'h130;
  localparam logic [8:0] IDX_FILT = 9'h131;
  localparam logic [8:0] IDX_OMSK = 9'h132;
  // timer_mode_select fields
  localparam int MODE_PWM = 0;
  localparam int MODE_TPWM = 1;
  localparam int MODE_BUF_A = 4;
  localparam int MODE_BUF_B = 5;
  localparam int MODE_RUN = 7;
  // timer_control_one fields
  localparam int CTL1_INIT_LO = 0;
  localparam int CTL1_SRC_LO = 4;
  localparam int CTL1_CLR = 7;
  // pin_io_control: one nibble per channel
  localparam int IO_EDGE_LO = 0;
  localparam int IO_CAPSEL = 2;
  localparam int IO_OPTION = 3;
  localparam int CTL2_TRIG_EN = 0;
  localparam int STAT_OVF = 7;
  // count source codes
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [2:0] SRC_OSC = 3'h6;
  // compare actions in timer mode
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [15:0] RST16 = 16'hFFFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [4:0] DIV_ZERO = 5'h00;
  localparam logic [7:0] STAT_MASK = 8'h8F;

  typedef struct packed {
    logic ovf;
    logic [2:0] rsv;
    logic [3:0] match;
  } cct_flags_t;
endpackage

// File: verilog/cct_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - capture ignores clear select and initial levels
// - capture counter runs freely and wraps
// - read one, then write zero, clears flag
// - zero write after zero read changes nothing
// - writing one never changes a flag
// - capture flag set on selected pin edge
// - compare flags A, B on counter match
// - flags C, D match even when buffering
// - overflow flag set in every mode
// - io control registers act only in timer mode
// - channel A option only when capturing
// - control two acts only in triggered PWM
// - filter acts in capture and triggered PWM
// - output mask acts outside timer capture
// - source 110b uses fast oscillator tick
// - C buffers A, D buffers B
module cct_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // avalon-mm slave, byte address
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // clock sources
  input wire logic fast_osc_tick,
  input wire logic capture_alt_tick,
  input wire logic ext_clk_pin,
  // channel pins a..d, bit 0 is a
  input wire logic [3:0] channel_pin_in,
  output logic [3:0] channel_pin_out,
  output logic [3:0] channel_pin_oe
);

  // pin synchronisers, bit 4 is the external clock
  logic [4:0] sy1_q, sy2_q, sy3_q, lvl_q, lvl_d;
  logic [3:0] h1_q, h2_q, flt_q, flt_d;
  logic [3:0] chl_q;
  logic extl_q;

  // registers
  logic [7:0] mode_q, ctl1_q, ien_q, ioab_q, iocd_q, ctl2_q, filt_q, omsk_q;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] gr_q [4];
  logic [15:0] gr_d [4];
  cct_pkg::cct_flags_t flags_q, flags_d;
  logic [7:0] seen_q, seen_d;
  logic [4:0] div_q;
  logic [3:0] out_q, out_d;
  logic armed_q, armed_d;
  logic ack_q;
  logic [31:0] rdata_q;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = sel[1] ? (rise | fall) : (sel[0] ? fall : rise);
  endfunction

  // bus decode
  wire [8:0] idx = avs_address[10:2];
  wire req = avs_read | avs_write;
  wire acc = req & ack_q;
  wire wr = avs_write & acc & avs_byteenable[0];
  wire rd_acc = avs_read & acc;
  wire s_mode = idx == cct_pkg::IDX_MODE;
  wire s_ctl1 = idx == cct_pkg::IDX_CTL1;
  wire s_ien = idx == cct_pkg::IDX_IEN;
  wire s_stat = idx == cct_pkg::IDX_STAT;
  wire s_ioab = idx == cct_pkg::IDX_IOAB;
  wire s_iocd = idx == cct_pkg::IDX_IOCD;
  wire s_cnt = idx == cct_pkg::IDX_CNT;
  wire s_ctl2 = idx == cct_pkg::IDX_CTL2;
  wire s_filt = idx == cct_pkg::IDX_FILT;
  wire s_omsk = idx == cct_pkg::IDX_OMSK;
  wire [3:0] s_gr = {idx == cct_pkg::IDX_GRD, idx == cct_pkg::IDX_GRC, idx == cct_pkg::IDX_GRB,
                     idx == cct_pkg::IDX_GRA};
  wire wr16 = avs_write & acc & (avs_byteenable[1:0] != 2'h0);

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  wire [31:0] rd_mux =
    s_mode ? {24'h000000, mode_q} :
    s_ctl1 ? {24'h000000, ctl1_q} :
    s_ien ? {24'h000000, ien_q} :
    s_stat ? {24'h000000, flags_q} :
    s_ioab ? {24'h000000, ioab_q} :
    s_iocd ? {24'h000000, iocd_q} :
    s_cnt ? {16'h0000, cnt_q} :
    s_gr[0] ? {16'h0000, gr_q[0]} :
    s_gr[1] ? {16'h0000, gr_q[1]} :
    s_gr[2] ? {16'h0000, gr_q[2]} :
    s_gr[3] ? {16'h0000, gr_q[3]} :
    s_ctl2 ? {24'h000000, ctl2_q} :
    s_filt ? {24'h000000, filt_q} :
    s_omsk ? {24'h000000, omsk_q} : 32'h00000000;

  // mode decode
  wire pwm = mode_q[cct_pkg::MODE_PWM] & ~mode_q[cct_pkg::MODE_TPWM];
  wire tpwm = mode_q[cct_pkg::MODE_TPWM];
  wire tmr = ~pwm & ~tpwm;
  wire run = mode_q[cct_pkg::MODE_RUN];
  wire [1:0] buf_en = {mode_q[cct_pkg::MODE_BUF_B], mode_q[cct_pkg::MODE_BUF_A]};
  wire [15:0] io = {iocd_q, ioab_q};
  wire [3:0] capsel = {io[12 + cct_pkg::IO_CAPSEL], io[8 + cct_pkg::IO_CAPSEL], io[4 + cct_pkg::IO_CAPSEL],
                       io[cct_pkg::IO_CAPSEL]};
  wire [3:0] cap = capsel & {4{tmr}};
  wire [3:0] cmp = ~cap;
  wire [3:0] init_lvl = ctl1_q[cct_pkg::CTL1_INIT_LO +: 4];
  wire [2:0] src = ctl1_q[cct_pkg::CTL1_SRC_LO +: 3];
  wire clr_en = ctl1_q[cct_pkg::CTL1_CLR] & ~cap[0];
  wire trig_en = tpwm & ctl2_q[cct_pkg::CTL2_TRIG_EN];
  // filter is honoured on capture pins, and on every pin in triggered pwm
  wire [3:0] filt_on = filt_q[3:0] & (cap | {4{tpwm}});

  // input levels: a change counts once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < 5; i++) begin
      if (sy2_q[i] == sy3_q[i]) begin
        lvl_d[i] = sy3_q[i];
      end
    end
    flt_d = flt_q;
    for (int i = 0; i < 4; i++) begin
      if (!filt_on[i]) begin
        flt_d[i] = lvl_q[i];
      end else if (h1_q[i] == lvl_q[i] && h2_q[i] == lvl_q[i]) begin
        flt_d[i] = lvl_q[i];
      end
    end
  end

  wire [3:0] rise = flt_q & ~chl_q;
  wire [3:0] fall = ~flt_q & chl_q;
  wire ext_rise = lvl_q[4] & ~extl_q;

  // count tick; every setting runs on sys_clk, the source only gates counting
  wire tick =
    (src == cct_pkg::SRC_DIV1) ? 1'b1 :
    (src == cct_pkg::SRC_DIV2) ? div_q[0] :
    (src == cct_pkg::SRC_DIV4) ? &div_q[1:0] :
    (src == cct_pkg::SRC_DIV8) ? &div_q[2:0] :
    (src == cct_pkg::SRC_DIV32) ? &div_q[4:0] :
    (src == cct_pkg::SRC_EXT) ? ext_rise :
    (src == cct_pkg::SRC_OSC) ? fast_osc_tick : 1'b0;

  wire cnt_tick = run & tick & (~trig_en | armed_q);
  wire ovf_ev = cnt_tick & (cnt_q == cct_pkg::CNT_MAX);
  wire [3:0] eq = {cnt_q == gr_q[3], cnt_q == gr_q[2], cnt_q == gr_q[1], cnt_q == gr_q[0]};
  wire [3:0] match = {4{cnt_tick}} & eq & cmp;
  wire period_end = match[0] & clr_en;

  // capture events per channel
  wire [3:0] pin_evt;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_edge
      assign pin_evt[g] = edge_hit(io[4 * g + cct_pkg::IO_EDGE_LO +: 2], rise[g], fall[g]);
    end
  endgenerate
  wire opt_a = capsel[0] & io[cct_pkg::IO_OPTION];
  wire [3:0] cap_evt = cap & {pin_evt[3:1], opt_a ? capture_alt_tick : pin_evt[0]};
  wire [3:0] set_ev = (cap & cap_evt) | (cmp & match);

  // buffer transfers
  wire xfer_a = buf_en[0] & cmp[0] & match[0];
  wire xfer_b = buf_en[1] & cmp[1] & (tpwm ? match[0] : match[1]);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gr_d[i] = (wr16 && s_gr[i]) ? merge16(gr_q[i], avs_writedata, avs_byteenable) : gr_q[i];
    end
    // buffered captures move old value to C/D; C/D pins then only raise flags
    for (int i = 0; i < 2; i++) begin
      if (cap_evt[i]) begin
        gr_d[i] = cnt_q;
        if (buf_en[i]) begin
          gr_d[i + 2] = gr_q[i];
        end
      end
      if (cap_evt[i + 2] && !buf_en[i]) begin
        gr_d[i + 2] = cnt_q;
      end
    end
    if (xfer_a) begin
      gr_d[0] = gr_q[2];
    end
    if (xfer_b) begin
      gr_d[1] = gr_q[3];
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (wr16 && s_cnt) begin
      cnt_d = merge16(cnt_q, avs_writedata, avs_byteenable);
    end else if (cnt_tick) begin
      cnt_d = period_end ? cct_pkg::CNT_ZERO : cnt_q + 16'h0001;
    end
  end

  // status flags: set wins over the zero write in the same cycle
  wire stat_wr = wr & s_stat;
  wire [7:0] clr = {8{stat_wr}} & ~avs_writedata[7:0] & seen_q & cct_pkg::STAT_MASK;
  always_comb begin
    flags_d = flags_q & ~clr;
    flags_d.match = flags_d.match | set_ev;
    flags_d.ovf = flags_d.ovf | ovf_ev;
    flags_d.rsv = 3'h0;
    seen_d = seen_q;
    if (stat_wr) begin
      seen_d = cct_pkg::RST8;
    end else if (rd_acc && s_stat) begin
      seen_d = seen_q | (rdata_q[7:0] & cct_pkg::STAT_MASK);
    end
  end

  assign irq = |(flags_q & ien_q);

  // outputs
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < 4; i++) begin
      if (!run) begin
        if (cmp[i]) begin
          out_d[i] = init_lvl[i];
        end
      end else if (tmr) begin
        if (match[i]) begin
          unique case (io[4 * i + cct_pkg::IO_EDGE_LO +: 2])
            cct_pkg::ACT_NONE: out_d[i] = out_q[i];
            cct_pkg::ACT_LOW: out_d[i] = 1'b0;
            cct_pkg::ACT_HIGH: out_d[i] = 1'b1;
            default: out_d[i] = ~out_q[i];
          endcase
        end
      end else if (i > 0) begin
        // pwm: period start restores the initial level, own match inverts it
        if (match[0] || ovf_ev) begin
          out_d[i] = init_lvl[i];
        end else if (match[i]) begin
          out_d[i] = ~init_lvl[i];
        end
      end
    end
  end

  assign channel_pin_out = out_q;
  // in pwm modes channel a is the period or trigger input, so it never drives
  assign channel_pin_oe = cmp & ~omsk_q[3:0] & {3'h7, tmr};

  // triggered pwm arming, one shot per period
  always_comb begin
    armed_d = armed_q;
    if (!trig_en || !run) begin
      armed_d = 1'b0;
    end else if (rise[0]) begin
      armed_d = 1'b1;
    end else if (match[0] || ovf_ev) begin
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    sy1_q <= {ext_clk_pin, channel_pin_in};
    sy2_q <= sy1_q;
    sy3_q <= sy2_q;
    h1_q <= lvl_q[3:0];
    h2_q <= h1_q;
    if (rst) begin
      lvl_q <= 5'h00;
      flt_q <= 4'h0;
      chl_q <= 4'h0;
      extl_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      flt_q <= flt_d;
      chl_q <= flt_q;
      extl_q <= lvl_q[4];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= cct_pkg::RST8;
      ctl1_q <= cct_pkg::RST8;
      ien_q <= cct_pkg::RST8;
      ioab_q <= cct_pkg::RST8;
      iocd_q <= cct_pkg::RST8;
      ctl2_q <= cct_pkg::RST8;
      filt_q <= cct_pkg::RST8;
      omsk_q <= cct_pkg::RST8;
    end else if (wr) begin
      // control one is taken even while running; keeping it still then is up to software
      if (s_mode) begin
        mode_q <= avs_writedata[7:0];
      end
      if (s_ctl1) begin
        ctl1_q <= avs_writedata[7:0];
      end
      // enables only exist where a status flag exists
      if (s_ien) begin
        ien_q <= avs_writedata[7:0] & cct_pkg::STAT_MASK;
      end
      if (s_ioab) begin
        ioab_q <= avs_writedata[7:0];
      end
      if (s_iocd) begin
        iocd_q <= avs_writedata[7:0];
      end
      if (s_ctl2) begin
        ctl2_q <= avs_writedata[7:0];
      end
      if (s_filt) begin
        filt_q <= avs_writedata[7:0];
      end
      if (s_omsk) begin
        omsk_q <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= cct_pkg::CNT_ZERO;
      for (int i = 0; i < 4; i++) begin
        gr_q[i] <= cct_pkg::RST16;
      end
      flags_q <= '0;
      seen_q <= cct_pkg::RST8;
      div_q <= cct_pkg::DIV_ZERO;
      out_q <= 4'h0;
      armed_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      for (int i = 0; i < 4; i++) begin
        gr_q[i] <= gr_d[i];
      end
      flags_q <= flags_d;
      seen_q <= seen_d;
      div_q <= div_q + 5'h01;
      out_q <= out_d;
      armed_q <= armed_d;
    end
  end

endmodule
